// *** uart_fifo_irq_baud_mode_tb_top.sv ***
// self-checking bench for the uart channel: register port, serial peer, irq
// assumes ufm_uart with default fifo depth and the peer model ufm_peer
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin bad_count++; \
  $display("Error %s expected %h seen %h", nm, ex, gt); end end
module uart_fifo_irq_baud_mode_tb_top;
  import ufm_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic        rx_pin;
  logic        tx_pin;
  logic        irq;
  logic [7:0]  v;
  logic [7:0]  sent[$];
  logic [31:0] seed = 32'h63C7;
  int          bad_count = 0;
  int          tests_run = 0;

  always #2 clk = ~clk;

  ufm_uart u_dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
                  .rd(rd), .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .irq(irq));
  ufm_peer #(.BIT_NS(640.0)) u_peer (.rx_line(rx_pin), .tx_line(tx_pin));

  // ==========================================
  // helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  function automatic logic [7:0] st_exp(input logic rdy, input logic fe, input logic idle);
    return {fe, idle, idle, 1'b0, fe, 2'b00, rdy};
  endfunction : st_exp

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] ex, input string nm);
    rd_reg(a, v);
    `CHK(nm, ex, v)
  endtask : chk_reg

  task automatic wait_irq(input logic lvl, input int n);
    for (int k = 0; k < n && irq !== lvl; k++) begin
      @(posedge clk);
      #1;
    end
    `CHK("irq wait", lvl, irq)
    if (irq !== lvl) begin
      summarize();
    end
  endtask : wait_irq

  task automatic send_rx(input int n, input logic bad);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      seed = xorshift(seed);
      b = seed[7:0] | 8'h01;
      sent.push_back(b);
      u_peer.send(b, bad);
    end
  endtask : send_rx

  task automatic drain(input int n);
    for (int i = 0; i < n; i++) begin
      rd_reg(A_DATA, v);
      `CHK("rx byte", sent.pop_front(), v)
    end
  endtask : drain

  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    chk_reg(A_MODE, MODE_RST, "mode reset");
    chk_reg(A_LINE_ST, st_exp(0, 0, 1), "status reset");
    seed = xorshift(seed);
    wr_reg(A_MODE, seed[7:0]);
    chk_reg(A_MODE, seed[7:0], "mode rw");
    chk_reg(8'h40, 8'h00, "unmapped");
    // 1.5M clocking: mode and divisor both set
    wr_reg(A_MODE, 8'h08);
    wr_reg(A_DLH, 8'h20);
    wr_reg(A_DLL, 8'h01);
    wr_reg(A_IDENT, 8'h41);
    wr_reg(A_IRQ_EN, 8'h01);
    send_rx(3, 1'b0);
    `CHK("irq below trigger", 1'b0, irq)
    chk_reg(A_LINE_ST, st_exp(1, 0, 1), "status ready");
    repeat (2000) @(posedge clk);
    `CHK("no early timeout", 1'b0, irq)
    wait_irq(1'b1, 6000);
    chk_reg(A_IDENT, {4'hC, ID_TIMEOUT}, "ident timeout");
    drain(1);
    chk_reg(A_IDENT, {4'hC, ID_NONE}, "ident after read");
    send_rx(2, 1'b0);
    wait_irq(1'b1, 100);
    chk_reg(A_IDENT, {4'hC, ID_RXDATA}, "ident trigger");
    drain(1);
    chk_reg(A_IDENT, {4'hC, ID_NONE}, "ident below trigger");
    drain(3);
    chk_reg(A_LINE_ST, st_exp(0, 0, 1), "status drained");
    // transmit side, receive polled
    wr_reg(A_IRQ_EN, 8'h02);
    seed = xorshift(seed);
    wr_reg(A_DATA, seed[7:0]);
    repeat (1000) @(posedge clk);
    `CHK("tx empty delayed", 1'b0, irq)
    wait_irq(1'b1, 1000);
    chk_reg(A_IDENT, {4'hC, ID_TXEMPTY}, "ident tx empty");
    chk_reg(A_IDENT, {4'hC, ID_NONE}, "ident read clears");
    for (int k = 0; k < 4000 && u_peer.got.size() == 0; k++) @(posedge clk);
    if (u_peer.got.size() == 0) begin
      bad_count++;
      summarize();
    end
    `CHK("tx byte", seed[7:0], u_peer.got.pop_front())
    repeat (200) @(posedge clk);
    chk_reg(A_LINE_ST, st_exp(0, 0, 1), "status tx idle");
    wr_reg(A_IDENT, 8'h40);
    repeat (3) @(posedge clk);
    `CHK("tx irq on fifo change", 1'b1, irq)
    wr_reg(A_IDENT, 8'h41);
    // fully polled
    wr_reg(A_IRQ_EN, 8'h00);
    send_rx(4, 1'b0);
    repeat (8000) @(posedge clk);
    `CHK("polled irq", 1'b0, irq)
    chk_reg(A_LINE_ST, st_exp(1, 0, 1), "status polled");
    drain(4);
    // framing error at head outranks trigger level
    wr_reg(A_IRQ_EN, 8'h05);
    send_rx(1, 1'b1);
    send_rx(3, 1'b0);
    wait_irq(1'b1, 100);
    chk_reg(A_IDENT, {4'hC, ID_LINEST}, "ident line status");
    chk_reg(A_LINE_ST, st_exp(1, 1, 1), "status framing");
    chk_reg(A_IDENT, {4'hC, ID_RXDATA}, "ident data after status");
    drain(4);
    summarize();
  end
endmodule : uart_fifo_irq_baud_mode_tb_top

// *** ufm_peer.sv ***
// serial peer model: drives the uart receive line, captures its transmit line
// assumes 8 data bits, no parity, lsb first, bit time given in ns
`timescale 1ns/100ps
module ufm_peer #(
  parameter real BIT_NS = 640.0
) (
  output logic      rx_line,
  input  wire logic tx_line
);
  logic [7:0] got[$];
  logic [7:0] sh;

  initial rx_line = 1'b1;

  // ==========================================
  // frame out, bad_stop gives a spacing stop bit
  task automatic send(input logic [7:0] b, input logic bad_stop);
    rx_line = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      rx_line = b[i];
      #(BIT_NS);
    end
    rx_line = ~bad_stop;
    #(BIT_NS);
    rx_line = 1'b1;
    #(BIT_NS * 2.0);
  endtask : send

  // ==========================================
  // frame in, sampled mid-bit
  always begin
    @(negedge tx_line);
    #(BIT_NS * 1.5);
    for (int i = 0; i < 8; i++) begin
      sh[i] = tx_line;
      #(BIT_NS);
    end
    got.push_back(sh);
  end
endmodule : ufm_peer

// *** ufm_pkg.sv ***
// constants for the fifo/irq/baud uart channel
// assumes a single 250 MHz core clock and a plain register port
package ufm_pkg;
  localparam int unsigned CLK_KHZ  = 250000;
  localparam int unsigned F_STD    = 1843;   // khz, 16x base for standard rates
  localparam int unsigned F_HS     = 7373;
  localparam int unsigned F_921    = 14746;
  localparam int unsigned F_1M5    = 24000;
  localparam int unsigned F_MIDI   = 2000;
  localparam logic [7:0]  PRE_STD  = 8'(CLK_KHZ / F_STD);
  localparam logic [7:0]  PRE_HS   = 8'(CLK_KHZ / F_HS);
  localparam logic [7:0]  PRE_921  = 8'(CLK_KHZ / F_921);
  localparam logic [7:0]  PRE_1M5  = 8'(CLK_KHZ / F_1M5);
  localparam logic [7:0]  PRE_MIDI = 8'(CLK_KHZ / F_MIDI);
  localparam int          FIFO_AW  = 4;
  // register offsets
  localparam logic [7:0]  A_DATA   = 8'h00;
  localparam logic [7:0]  A_IRQ_EN  = 8'h01;
  localparam logic [7:0]  A_IDENT   = 8'h02;
  localparam logic [7:0]  A_LCR     = 8'h03;
  localparam logic [7:0]  A_LINE_ST = 8'h05;
  localparam logic [7:0]  A_DLL    = 8'h08;
  localparam logic [7:0]  A_DLH    = 8'h09;
  localparam logic [7:0]  A_MODE   = 8'hF0;
  localparam logic [7:0]  MODE_RST = 8'h00;
  localparam logic [15:0] DIV_RST  = 16'h0001;
  // field positions
  localparam int MODE_MIDI = 0;
  localparam int MODE_HS   = 1;
  localparam int MODE_EF   = 2;
  localparam int DIV_HSB   = 15;
  localparam int DIV_921B  = 14;
  localparam int DIV_1M5B  = 13;
  localparam int DIV_W     = 13;
  localparam int EN_RXDATA  = 0;
  localparam int EN_TXEMPTY = 1;
  localparam int EN_LINEST  = 2;
  localparam int FC_ENABLE  = 0;
  localparam int FC_RXCLR   = 1;
  localparam int FC_TXCLR   = 2;
  localparam int FC_TRIG    = 6;
  localparam int LCR_STOP2 = 2;
  localparam logic [1:0] EF_921 = 2'b01;
  localparam logic [1:0] EF_1M5 = 2'b10;
  // identification codes, low nibble
  localparam logic [3:0] ID_NONE    = 4'h1;
  localparam logic [3:0] ID_LINEST  = 4'h6;
  localparam logic [3:0] ID_RXDATA  = 4'h4;
  localparam logic [3:0] ID_TIMEOUT = 4'hC;
  localparam logic [3:0] ID_TXEMPTY = 4'h2;
  // frame timing in 16x ticks
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] HALF_BIT = 4'h7;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [9:0] BIT_TICKS   = 10'h010;
  localparam logic [9:0] FRAME_TICKS = 10'h0A0;  // start + 8 data + 1 stop
  localparam int         TO_CHARS    = 4;
  localparam logic [4:0] TRIG_1  = 5'h01;
  localparam logic [4:0] TRIG_4  = 5'h04;
  localparam logic [4:0] TRIG_8  = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0E;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b10,
    ST_STOP  = 2'b11
  } ufm_ser_t;
endpackage : ufm_pkg

// *** ufm_uart.sv ***
// uart channel: 16-byte fifos, irq identification, line status, speed mode
// assumes a synchronous register master and an asynchronous serial peer
//
// Contract
// - rx data irq and ident while fifo fill is at or above trigger level.
// - line status irq (06) outranks received data available (04).
// - fifo mode data ready sets on push, clears when fifo empties.
// - timeout irq when fifo holds data and no push or pop for 4 chars.
// - character times are counted in 16x bit clock ticks.
// - pending timeout clears and timer restarts on one host fifo read.
// - without pending timeout, timer restarts on receive or host read.
// - tx holding empty irq (02) on empty fifo, cleared by write or ident read.
// - empty irq delayed one char minus stop unless fifo held two bytes.
// - changing the fifo enable bit raises tx irq at once.
// - timeout ranks with rx data, tx fifo empty with holding empty.
// - fifos on with irq enables off gives polled mode, rx and tx apart.
// - polled line status: ready, errors, tx empty, both empty, fifo error.
// - polled mode shows no trigger or timeout, fifos still store data.
// - eight-bit speed mode register at 0xF0, reset to zero.
// - mode bit 0 enables midi clocking.
// - mode bit 1 enables high-speed clocking.
// - mode bits 3:2 pick standard, 921k or 1.5M clocking.
// - mode bits clear: 13-bit divisor sets the standard 16x clock.
// - baud generator runs at 16x baud and clocks rx and tx.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
module ufm_uart
  import ufm_pkg::*;
#(
  parameter int AW = ufm_pkg::FIFO_AW
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       rx_pin,
  output logic            tx_pin,
  output logic            irq
);
  import ufm_pkg::*;
  localparam int DEPTH = 1 << AW;
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [3:0]             irq_en;
    logic                   fifo_en;
    logic [1:0]             trig;
    logic                   two_stop;
    logic [15:0]            div;
    logic [7:0]             mode;
    logic [7:0]             pre_cnt;
    logic [DIV_W-1:0]       div_cnt;
    logic                   tick;
    logic                   rx_s1;
    logic                   rx_s2;
    ufm_ser_t               rx_st;
    logic [3:0]             rx_ph;
    logic [3:0]             rx_bit;
    logic [7:0]             rx_sh;
    logic [DEPTH-1:0][9:0]  rx_mem;
    logic [AW-1:0]          rx_wp;
    logic [AW-1:0]          rx_rp;
    logic [AW:0]            rx_n;
    logic [AW:0]            rx_errn;
    logic                   oe;
    logic                   fe;
    logic                   bi;
    logic [9:0]             to_cnt;
    logic                   to_pend;
    logic [DEPTH-1:0][7:0]  tx_mem;
    logic [AW-1:0]          tx_wp;
    logic [AW-1:0]          tx_rp;
    logic [AW:0]            tx_n;
    logic                   tx_two;
    ufm_ser_t               tx_st;
    logic [3:0]             tx_ph;
    logic [3:0]             tx_bit;
    logic [7:0]             tx_sh;
    logic                   tx_out;
    logic                   txe_flag;
    logic                   dly_on;
    logic [9:0]             dly_cnt;
    logic [7:0]             rdata;
    logic                   irq;
  } ufm_state_t;

  ufm_state_t s;
  ufm_state_t next_s;

  logic [7:0]       pre;
  logic [DIV_W-1:0] divv;
  logic [1:0]       ef;
  logic [9:0]       char_ticks;
  logic [9:0]       to_limit;
  logic [4:0]       trig_lvl;
  logic [7:0]       line_st;
  logic             ls_int;
  logic             rda_int;
  logic             to_int;
  logic             txe_int;
  logic [3:0]       ident_code;
  logic             push;
  logic             pop;
  logic             en_flip;
  logic             empty_evt;
  logic             head_new;
  logic [9:0]       push_word;
  logic             rx_in;
  logic             tx_in;
  logic             tx_pop;

  assign rdata  = s.rdata;
  assign tx_pin = s.tx_out;
  assign irq    = s.irq;

  // ==========================================================
  // clock select and status decode
  always_comb begin
    ef = (s.mode[MODE_EF +: 2] == (EF_921 | EF_1M5)) ? 2'b00 : s.mode[MODE_EF +: 2];
    if (s.mode[MODE_MIDI]) begin
      pre = PRE_MIDI;
    end else if (ef == EF_1M5 && s.div[DIV_1M5B]) begin
      pre = PRE_1M5;
    end else if (ef == EF_921 && s.mode[MODE_HS] && s.div[DIV_921B]) begin
      pre = PRE_921;
    end else if (s.mode[MODE_HS] && s.div[DIV_HSB]) begin
      pre = PRE_HS;
    end else begin
      pre = PRE_STD;
    end
    divv = (s.div[DIV_W-1:0] == '0) ? DIV_W'(1) : s.div[DIV_W-1:0];
    char_ticks = s.two_stop ? FRAME_TICKS + BIT_TICKS : FRAME_TICKS;
    to_limit   = 10'(TO_CHARS * char_ticks);
    unique case (s.trig)
      2'b00: trig_lvl = TRIG_1;
      2'b01: trig_lvl = TRIG_4;
      2'b10: trig_lvl = TRIG_8;
      2'b11: trig_lvl = TRIG_14;
    endcase
    line_st = {s.fifo_en && s.rx_errn != '0, s.tx_n == '0 && s.tx_st == ST_IDLE,
               s.tx_n == '0, s.bi, s.fe, 1'b0, s.oe, s.rx_n != '0};
    ls_int  = s.irq_en[EN_LINEST] && (s.oe || s.fe || s.bi);
    rda_int = s.irq_en[EN_RXDATA] && (s.fifo_en ? s.rx_n >= trig_lvl : s.rx_n != '0);
    to_int  = s.irq_en[EN_RXDATA] && s.fifo_en && s.to_pend;
    txe_int = s.irq_en[EN_TXEMPTY] && s.txe_flag;
    if (ls_int) begin
      ident_code = ID_LINEST;
    end else if (rda_int) begin
      ident_code = ID_RXDATA;
    end else if (to_int) begin
      ident_code = ID_TIMEOUT;
    end else if (txe_int) begin
      ident_code = ID_TXEMPTY;
    end else begin
      ident_code = ID_NONE;
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    next_s     = s;
    push       = 1'b0;
    push_word  = '0;
    pop        = rd && addr == A_DATA && s.rx_n != '0;
    en_flip    = wr && addr == A_IDENT && wdata[FC_ENABLE] != s.fifo_en;
    rx_in      = 1'b0;
    tx_in      = 1'b0;
    tx_pop     = 1'b0;
    empty_evt  = 1'b0;
    head_new   = 1'b0;
    next_s.tick = 1'b0;

    // baud generator, one 16x tick per divided period
    if (s.pre_cnt == '0) begin
      next_s.pre_cnt = pre - 8'h01;
      if (s.div_cnt == '0) begin
        next_s.div_cnt = divv - DIV_W'(1);
        next_s.tick    = 1'b1;
      end else begin
        next_s.div_cnt = s.div_cnt - DIV_W'(1);
      end
    end else begin
      next_s.pre_cnt = s.pre_cnt - 8'h01;
    end

    next_s.rx_s1 = rx_pin;
    next_s.rx_s2 = s.rx_s1;

    // receiver
    if (s.tick) begin
      next_s.rx_ph = s.rx_ph + 4'h1;
      unique case (s.rx_st)
        ST_IDLE: begin
          next_s.rx_ph = '0;
          if (!s.rx_s2) begin
            next_s.rx_st = ST_START;
          end
        end
        ST_START: begin
          if (s.rx_ph == HALF_BIT) begin
            next_s.rx_ph  = '0;
            next_s.rx_bit = '0;
            next_s.rx_st  = s.rx_s2 ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (s.rx_ph == OVS_LAST) begin
            next_s.rx_sh  = {s.rx_s2, s.rx_sh[7:1]};
            next_s.rx_bit = s.rx_bit + 4'h1;
            if (s.rx_bit == LAST_BIT) begin
              next_s.rx_st = ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (s.rx_ph == OVS_LAST) begin
            push         = 1'b1;
            push_word    = {!s.rx_s2 && s.rx_sh == '0, !s.rx_s2, s.rx_sh};
            next_s.rx_st = ST_IDLE;
          end
        end
      endcase
    end

    // receive fifo; depth one outside fifo mode
    if (pop) begin
      next_s.rdata = s.rx_mem[s.rx_rp][7:0];
      next_s.rx_rp = s.rx_rp + AW'(1);
      if (s.rx_mem[s.rx_rp][9:8] != '0) begin
        next_s.rx_errn = next_s.rx_errn - (AW+1)'(1);
      end
      head_new = s.rx_n > (AW+1)'(1);
    end
    if (push) begin
      if (s.rx_n == (s.fifo_en ? FULL : (AW+1)'(1)) && !pop) begin
        next_s.oe = 1'b1;
      end else begin
        next_s.rx_mem[s.rx_wp] = push_word;
        next_s.rx_wp = s.rx_wp + AW'(1);
        rx_in        = 1'b1;
        if (push_word[9:8] != '0) begin
          next_s.rx_errn = next_s.rx_errn + (AW+1)'(1);
        end
        head_new = head_new || s.rx_n == '0;
      end
    end
    // fill counted, pointers alone cannot tell full from empty
    next_s.rx_n = s.rx_n + (AW+1)'(rx_in) - (AW+1)'(pop);

    // character timeout
    if (s.rx_n == '0 || push || pop) begin
      next_s.to_cnt  = '0;
      next_s.to_pend = 1'b0;
    end else if (s.tick && !s.to_pend) begin
      next_s.to_cnt = s.to_cnt + 10'h001;
      if (s.to_cnt == to_limit - 10'h001) begin
        next_s.to_pend = 1'b1;
      end
    end

    // transmitter
    if (s.tick) begin
      next_s.tx_ph = s.tx_ph + 4'h1;
      unique case (s.tx_st)
        ST_IDLE: begin
          next_s.tx_ph = '0;
          if (s.tx_n != '0) begin
            next_s.tx_sh  = s.tx_mem[s.tx_rp];
            next_s.tx_rp  = s.tx_rp + AW'(1);
            tx_pop        = 1'b1;
            next_s.tx_out = 1'b0;
            next_s.tx_st  = ST_START;
          end
        end
        ST_START: begin
          if (s.tx_ph == OVS_LAST) begin
            next_s.tx_out = s.tx_sh[0];
            next_s.tx_bit = '0;
            next_s.tx_st  = ST_DATA;
          end
        end
        ST_DATA: begin
          if (s.tx_ph == OVS_LAST) begin
            if (s.tx_bit == LAST_BIT) begin
              next_s.tx_out = 1'b1;
              next_s.tx_bit = '0;
              next_s.tx_st  = ST_STOP;
            end else begin
              next_s.tx_out = s.tx_sh[1];
              next_s.tx_sh  = {1'b0, s.tx_sh[7:1]};
              next_s.tx_bit = s.tx_bit + 4'h1;
            end
          end
        end
        ST_STOP: begin
          if (s.tx_ph == OVS_LAST) begin
            if (s.two_stop && s.tx_bit == '0) begin
              next_s.tx_bit = 4'h1;
            end else begin
              next_s.tx_st = ST_IDLE;
            end
          end
        end
      endcase
    end
    if (wr && addr == A_DATA && s.tx_n != (s.fifo_en ? FULL : (AW+1)'(1))) begin
      next_s.tx_mem[s.tx_wp] = wdata;
      next_s.tx_wp = s.tx_wp + AW'(1);
      tx_in        = 1'b1;
    end

    // register writes
    if (wr) begin
      unique case (addr)
        A_IRQ_EN: next_s.irq_en   = wdata[3:0];
        A_LCR:    next_s.two_stop = wdata[LCR_STOP2];
        A_DLL:    next_s.div[7:0] = wdata;
        A_DLH:    next_s.div[15:8] = wdata;
        A_MODE:   next_s.mode     = wdata;
        A_IDENT: begin
          next_s.fifo_en = wdata[FC_ENABLE];
          next_s.trig    = wdata[FC_TRIG +: 2];
          if (wdata[FC_RXCLR] || en_flip) begin
            next_s.rx_wp   = '0;
            next_s.rx_rp   = '0;
            next_s.rx_errn = '0;
          end
          if (wdata[FC_TXCLR] || en_flip) begin
            next_s.tx_wp = '0;
            next_s.tx_rp = '0;
          end
        end
        default: ;
      endcase
      if (addr == A_DLL || addr == A_DLH) begin
        next_s.pre_cnt = '0;
        next_s.div_cnt = '0;
      end
    end
    if (wr && addr == A_IDENT && (wdata[FC_RXCLR] || en_flip)) begin
      next_s.rx_n = '0;
    end
    next_s.tx_n = s.tx_n + (AW+1)'(tx_in) - (AW+1)'(tx_pop);
    if (wr && addr == A_IDENT && (wdata[FC_TXCLR] || en_flip)) begin
      next_s.tx_n = '0;
    end

    // transmit empty interrupt
    if (next_s.tx_n >= (AW+1)'(2)) begin
      next_s.tx_two = 1'b1;
    end
    if (wr && (addr == A_DATA || (addr == A_IDENT && !en_flip))) begin
      next_s.txe_flag = 1'b0;
    end
    if (rd && addr == A_IDENT && ident_code == ID_TXEMPTY) begin
      next_s.txe_flag = 1'b0;
    end
    if (wr && addr == A_DATA) begin
      next_s.dly_on = 1'b0;
    end
    empty_evt = s.tx_n != '0 && next_s.tx_n == '0;
    if (empty_evt) begin
      next_s.tx_two = 1'b0;
      if (s.tx_two) begin
        next_s.txe_flag = 1'b1;
      end else begin
        next_s.dly_on  = 1'b1;
        next_s.dly_cnt = '0;
      end
    end else if (s.dly_on && s.tick) begin
      next_s.dly_cnt = s.dly_cnt + 10'h001;
      if (s.dly_cnt == char_ticks - BIT_TICKS - 10'h001) begin
        next_s.dly_on   = 1'b0;
        next_s.txe_flag = 1'b1;
      end
    end
    if (en_flip) begin
      next_s.dly_on   = 1'b0;
      next_s.txe_flag = 1'b1;
    end

    // line status: sticky errors, head errors latched as they surface
    if (rd && addr == A_LINE_ST) begin
      next_s.oe = 1'b0;
      next_s.fe = 1'b0;
      next_s.bi = 1'b0;
    end
    if (push && s.rx_n == (s.fifo_en ? FULL : (AW+1)'(1)) && !pop) begin
      next_s.oe = 1'b1;
    end
    if (head_new) begin
      next_s.fe = next_s.fe || next_s.rx_mem[next_s.rx_rp][8];
      next_s.bi = next_s.bi || next_s.rx_mem[next_s.rx_rp][9];
    end

    // read data
    if (rd) begin
      unique case (addr)
        A_DATA:  next_s.rdata = pop ? s.rx_mem[s.rx_rp][7:0] : 8'h00;
        A_IRQ_EN:  next_s.rdata = {4'h0, s.irq_en};
        A_IDENT:   next_s.rdata = {{2{s.fifo_en}}, 2'b00, ident_code};
        A_LCR:     next_s.rdata = {5'h00, s.two_stop, 2'b11};
        A_LINE_ST: next_s.rdata = line_st;
        A_DLL:   next_s.rdata = s.div[7:0];
        A_DLH:   next_s.rdata = s.div[15:8];
        A_MODE:  next_s.rdata = s.mode;
        default: next_s.rdata = 8'h00;
      endcase
    end else begin
      next_s.rdata = 8'h00;
    end
    next_s.irq = ls_int || rda_int || to_int || txe_int;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s          <= '0;
      s.div      <= DIV_RST;
      s.mode     <= MODE_RST;
      s.rx_s1    <= 1'b1;
      s.rx_s2    <= 1'b1;
      s.tx_out   <= 1'b1;
      s.rx_st    <= ST_IDLE;
      s.tx_st    <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // checks
  sequence s_en_toggle;
    wr && addr == A_IDENT && wdata[FC_ENABLE] != s.fifo_en;
  endsequence
  sequence s_data_write;
    wr && addr == A_DATA && !empty_evt && !en_flip && !(s.dly_on && s.tick);
  endsequence

  rx_level_irq_a: assert property (@(posedge clk) disable iff (!reset_n)
    (s.irq_en == 4'h1 && s.fifo_en && s.rx_n >= trig_lvl) |-> ##1 s.irq ##1 1'b1)
    else $error("trigger level reached without irq");
  ls_priority_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rd && addr == A_IDENT && ls_int) |=> s.rdata[3:0] == ID_LINEST)
    else $error("line status not highest");
  data_ready_a: assert property (@(posedge clk) disable iff (!reset_n)
    (push && s.rx_n == '0 && !wr) |=> line_st[0] || $past(pop))
    else $error("data ready not set");
  timeout_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(s.to_pend) |-> s.rx_n != '0 && s.to_cnt == to_limit)
    else $error("timeout at wrong count");
  timeout_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    (s.to_pend && pop) |=> !s.to_pend && s.to_cnt == '0)
    else $error("timeout not cleared by read");
  txe_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    s_data_write |=> !s.txe_flag)
    else $error("tx irq not cleared by write");
  en_change_a: assert property (@(posedge clk) disable iff (!reset_n)
    s_en_toggle |=> s.txe_flag ##1 (s.irq || !s.irq_en[EN_TXEMPTY]))
    else $error("tx irq not immediate");
  polled_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
    (s.fifo_en && !s.irq_en[EN_RXDATA]) |-> ident_code != ID_RXDATA && ident_code != ID_TIMEOUT)
    else $error("polled mode shows rx irq");
  mode_reset_a: assert property (@(posedge clk)
    $rose(reset_n) |-> s.mode == MODE_RST)
    else $error("mode register not reset");
endmodule : ufm_uart
